// ===== logic/comparator_mode_irq_control.sv
// Mode select and control registers of the analog comparator, edge
// detection and the comparator interrupt request.
// Assumes a single-cycle 8-bit register bus on clk; the analog output
// arrives asynchronously and is synchronised here.
module comparator_mode_irq_control (
    input  wire logic                              clk,
    input  wire logic                              rstn,
    input  wire logic [7:0]                        regAddr,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    input  wire logic [7:0]                        regWriteData,
    output logic      [7:0]                        regReadData,
    input  wire logic                              compareIn,
    output logic                                   comparatorEnable,
    output logic      [3:0]                        hysteresisSelect,
    output comparator_mode_pkg::resp_mode_t        responseSelect,
    output logic                                   comparatorPinOut,
    output logic                                   comparatorIrq
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Asserts at once, leaves two edges later, free of glitches
    logic rstSync1;
    logic rstSync2;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Registered copy of every output, so no output is combinational
    typedef struct packed {
        comparator_mode_pkg::mode_reg_t  mode;
        logic                            enable;
        logic [3:0]                      hyst;
        logic                            inMeta;
        logic                            inSync;
        logic                            outPrev;
        logic [7:0]                      readData;
        logic                            irq;
        logic                            pinOut;
        comparator_mode_pkg::resp_mode_t resp;
    } ctrl_state_t;

    // Reset image built from the register reset words
    localparam logic [7:0] MODE_RESET = comparator_mode_pkg::MODE_SELECT_RESET;
    localparam logic [7:0] CTRL_RESET = comparator_mode_pkg::CONTROL_RESET;
    localparam comparator_mode_pkg::mode_reg_t MODE_RESET_FIELDS = '{
        riseIrqEnable: MODE_RESET[comparator_mode_pkg::RISE_IE_BIT],
        fallIrqEnable: MODE_RESET[comparator_mode_pkg::FALL_IE_BIT],
        responseMode:  MODE_RESET[1:0]
    };
    // Resp must stay the one-hot decode of the mode reset field
    localparam ctrl_state_t RESET_STATE = '{
        mode:     MODE_RESET_FIELDS,
        enable:   CTRL_RESET[comparator_mode_pkg::ENABLE_BIT],
        hyst:     CTRL_RESET[comparator_mode_pkg::HYST_LSB
                             +: comparator_mode_pkg::HYST_W],
        inMeta:   1'b0,
        inSync:   1'b0,
        outPrev:  1'b0,
        readData: 8'h00,
        irq:      1'b0,
        pinOut:   1'b0,
        resp:     comparator_mode_pkg::RESP_SLOW
    };

    ctrl_state_t state;
    ctrl_state_t next_state;

    edge_flag_if flagBus ();

    // Flags live apart so set-beats-clear sits in one place
    edge_flag_keeper flagKeeper (
        .clk   (clk),
        .rstn  (rstSync2),
        .flags (flagBus)
    );

    logic       writeMode;
    logic       writeControl;
    logic       compOut;
    logic [7:0] modeWriteData;
    logic [7:0] modeWord;
    logic [7:0] controlWord;

    // ------------------------------------------------------------
    // Decode and edge events
    // ------------------------------------------------------------
    always_comb begin
        // Single-cycle bus: no wait states, no read side effects
        writeMode    = 1'b0;
        writeControl = 1'b0;
        if (regWrite && regAddr == comparator_mode_pkg::MODE_SELECT_ADDR) begin
            writeMode = 1'b1;
        end else if (regWrite
                     && regAddr == comparator_mode_pkg::CONTROL_ADDR) begin
            writeControl = 1'b1;
        end
    end

    // Output only meaningful while enabled
    assign compOut = state.enable & state.inSync;

    // Unused mode bits never reach the register
    assign modeWriteData = regWriteData
        & comparator_mode_pkg::MODE_SELECT_MASK;

    // Flags are read-write: writing zero clears, writing one is ignored
    assign flagBus.riseEvent = compOut & ~state.outPrev;
    assign flagBus.fallEvent = ~compOut & state.outPrev;
    assign flagBus.riseClear = writeControl
        & ~regWriteData[comparator_mode_pkg::RISE_FLAG_BIT];
    assign flagBus.fallClear = writeControl
        & ~regWriteData[comparator_mode_pkg::FALL_FLAG_BIT];

    // ------------------------------------------------------------
    // Read-back words
    // ------------------------------------------------------------
    always_comb begin
        modeWord = 8'h00;
        modeWord[comparator_mode_pkg::RISE_IE_BIT] = state.mode.riseIrqEnable;
        modeWord[comparator_mode_pkg::FALL_IE_BIT] = state.mode.fallIrqEnable;
        modeWord[1:0] = state.mode.responseMode;
        // Output bit is live and read-only; writes never reach it
        controlWord = 8'h00;
        controlWord[comparator_mode_pkg::ENABLE_BIT] = state.enable;
        controlWord[comparator_mode_pkg::OUT_BIT] = compOut;
        controlWord[comparator_mode_pkg::RISE_FLAG_BIT] =
            flagBus.riseEdgeFlag;
        controlWord[comparator_mode_pkg::FALL_FLAG_BIT] =
            flagBus.fallEdgeFlag;
        controlWord[comparator_mode_pkg::HYST_LSB
                    +: comparator_mode_pkg::HYST_W] = state.hyst;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        // Two flops on the asynchronous comparator output
        next_state.inMeta  = compareIn;
        next_state.inSync  = state.inMeta;
        next_state.outPrev = compOut;
        if (writeMode) begin
            // Only the enable and mode bits take; the rest is dropped
            next_state.mode.riseIrqEnable =
                modeWriteData[comparator_mode_pkg::RISE_IE_BIT];
            next_state.mode.fallIrqEnable =
                modeWriteData[comparator_mode_pkg::FALL_IE_BIT];
            next_state.mode.responseMode = modeWriteData[1:0];
        end
        if (writeControl) begin
            next_state.enable =
                regWriteData[comparator_mode_pkg::ENABLE_BIT];
            next_state.hyst = regWriteData[comparator_mode_pkg::HYST_LSB
                                           +: comparator_mode_pkg::HYST_W];
        end
        case (next_state.mode.responseMode)
            2'b00:   next_state.resp = comparator_mode_pkg::RESP_FAST;
            2'b01:   next_state.resp = comparator_mode_pkg::RESP_MEDIUM;
            2'b10:   next_state.resp = comparator_mode_pkg::RESP_SLOW;
            default: next_state.resp = comparator_mode_pkg::RESP_SLOWEST;
        endcase
        // Pin drops in the same cycle as the enable, never after
        next_state.pinOut = next_state.enable & state.inSync;
        // Irq trails its flag by one cycle so it leaves a flop
        next_state.irq =
            (flagBus.riseEdgeFlag & state.mode.riseIrqEnable)
            | (flagBus.fallEdgeFlag & state.mode.fallIrqEnable);
        next_state.readData = 8'h00;
        if (regRead && regAddr == comparator_mode_pkg::MODE_SELECT_ADDR) begin
            next_state.readData = modeWord;
        end else if (regRead
                     && regAddr == comparator_mode_pkg::CONTROL_ADDR) begin
            next_state.readData = controlWord;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regReadData      = state.readData;
    assign comparatorEnable = state.enable;
    assign hysteresisSelect = state.hyst;
    assign responseSelect   = state.resp;
    assign comparatorPinOut = state.pinOut;
    assign comparatorIrq    = state.irq;
endmodule

// ===== logic/edge_flag_keeper.sv
// Sticky rising and falling edge flags.
// Assumes events and clears are one-cycle pulses on clk.
module edge_flag_keeper (
    input  wire logic   clk,
    input  wire logic   rstn,
    edge_flag_if.owner  flags
);
    typedef struct packed {
        logic rise;
        logic fall;
    } flag_state_t;

    flag_state_t state;
    flag_state_t next_state;

    // Set beats clear so an edge in the clearing cycle survives
    always_comb begin
        next_state = state;
        if (flags.riseClear) begin
            next_state.rise = 1'b0;
        end
        if (flags.fallClear) begin
            next_state.fall = 1'b0;
        end
        if (flags.riseEvent) begin
            next_state.rise = 1'b1;
        end
        if (flags.fallEvent) begin
            next_state.fall = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flags.riseEdgeFlag = state.rise;
    assign flags.fallEdgeFlag = state.fall;
endmodule

// ===== pkg/comparator_mode_pkg.sv
// Constants and types for the comparator mode and edge-interrupt block.
// Assumes an 8-bit special-function register bus inside the same clock domain.
package comparator_mode_pkg;
    localparam logic [7:0] MODE_SELECT_ADDR  = 8'h9d;
    localparam logic [7:0] CONTROL_ADDR      = 8'h9b;
    localparam logic [7:0] MODE_SELECT_RESET = 8'h02;
    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic [7:0] MODE_SELECT_MASK  = 8'h33;
    localparam int RISE_IE_BIT   = 5;
    localparam int FALL_IE_BIT   = 4;
    localparam int ENABLE_BIT    = 7;
    localparam int OUT_BIT       = 6;
    localparam int RISE_FLAG_BIT = 5;
    localparam int FALL_FLAG_BIT = 4;
    localparam int HYST_LSB      = 0;
    localparam int HYST_W        = 4;
    // Typical response times per mode, in ns
    localparam int RESP_NS_MODE0 = 100;
    localparam int RESP_NS_MODE1 = 175;
    localparam int RESP_NS_MODE2 = 320;
    localparam int RESP_NS_MODE3 = 1050;
    localparam int CLK_PERIOD_NS = 5;
    localparam int POWER_UP_NS   = 10000;
    localparam int POWER_UP_CYCLES = POWER_UP_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        RESP_FAST     = 4'h1,
        RESP_MEDIUM   = 4'h2,
        RESP_SLOW     = 4'h4,
        RESP_SLOWEST  = 4'h8
    } resp_mode_t;

    typedef struct packed {
        logic       riseIrqEnable;
        logic       fallIrqEnable;
        logic [1:0] responseMode;
    } mode_reg_t;
endpackage

// ===== pkg/edge_flag_if.sv
// Carries edge events and flag clears between the top and the flag module.
// Assumes both ends sit on the same clock.
interface edge_flag_if;
    logic riseEvent;
    logic fallEvent;
    logic riseClear;
    logic fallClear;
    logic riseEdgeFlag;
    logic fallEdgeFlag;
    modport owner (input riseEvent, fallEvent, riseClear, fallClear,
                   output riseEdgeFlag, fallEdgeFlag);
    modport user  (output riseEvent, fallEvent, riseClear, fallClear,
                   input riseEdgeFlag, fallEdgeFlag);
endinterface

// ===== tb/comparator_mode_irq_control_assertions.sv
// Checker of the comparator mode block, seeing its top ports only.
// Assumes a single clock and the bind below.
module comparator_mode_irq_control_checker (
    input wire logic                       clk,
    input wire logic                       rstn,
    input wire logic [7:0]                 regAddr,
    input wire logic                       regWrite,
    input wire logic                       regRead,
    input wire logic [7:0]                 regWriteData,
    input wire logic [7:0]                 regReadData,
    input wire logic                       comparatorEnable,
    input wire logic [3:0]                 hysteresisSelect,
    input comparator_mode_pkg::resp_mode_t responseSelect,
    input wire logic                       comparatorPinOut,
    input wire logic                       comparatorIrq
);
    // ------------------------------------------------------------
    // Shadow of the mode register
    // ------------------------------------------------------------
    logic [7:0] shadow;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) shadow <= 8'h02;
        else if (regWrite && regAddr == 8'h9d)
            shadow <= regWriteData & 8'h33;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_mode_readback: assert property (
        regRead && !regWrite && regAddr == 8'h9d
        |=> regReadData == $past(shadow)) else $error("mode readback");
    chk_read_idle: assert property (
        !regRead |=> regReadData == 8'h00) else $error("idle read data");
    chk_unmapped_zero: assert property (
        regRead && regAddr != 8'h9d && regAddr != 8'h9b
        |=> regReadData == 8'h00) else $error("unmapped read");
    chk_resp_decode: assert property (
        responseSelect == (4'h1 << shadow[1:0])) else $error("decode");
    chk_pin_low: assert property (
        !comparatorEnable && $past(!comparatorEnable)
        |-> !comparatorPinOut) else $error("pin not low");
    chk_irq_masked: assert property (
        (regWrite && regAddr == 8'h9d && regWriteData[5:4] == 2'b00)
        ##1 !regWrite |=> !comparatorIrq) else $error("irq not masked");
    chk_irq_cause: assert property (
        $rose(comparatorIrq) |-> (shadow[5:4] | $past(shadow[5:4]))
        != 2'b00) else $error("irq without enable");
    chk_ctrl_write: assert property (
        regWrite && regAddr == 8'h9b |=> hysteresisSelect ==
        $past(regWriteData[3:0]) && comparatorEnable ==
        $past(regWriteData[7])) else $error("control write");
endmodule

bind comparator_mode_irq_control comparator_mode_irq_control_checker u_chk (
    .clk, .rstn, .regAddr, .regWrite, .regRead, .regWriteData,
    .regReadData, .comparatorEnable, .hysteresisSelect, .responseSelect,
    .comparatorPinOut, .comparatorIrq);

// ===== tb/test_comparator_mode_irq_control.sv
// Self-checking bench of the comparator mode block.
// Assumes the design drives registered outputs on the rising edge.
`define CHECK(name, exp, got) begin check_count++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", name, exp, got); end end
module test_comparator_mode_irq_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus, notes queue and result watcher
    // ------------------------------------------------------------
    logic clk, rstn, regWrite, regRead, compareIn, readSeen;
    logic comparatorEnable, comparatorPinOut, comparatorIrq;
    logic [7:0] regAddr, regWriteData, regReadData, d, note;
    logic [3:0] hysteresisSelect;
    logic [7:0] noteQ[$];
    comparator_mode_pkg::resp_mode_t responseSelect;
    int err_total, check_count, seed = 41;
    comparator_mode_irq_control u_comparator_mode_irq_control (.clk,
        .rstn, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData,
        .compareIn, .comparatorEnable, .hysteresisSelect, .responseSelect,
        .comparatorPinOut, .comparatorIrq);
    task stop_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Holds the request one cycle; never lowers it, so calls chain
    task op(input logic w, r, input logic [7:0] a, dat, e);
        regWrite = w;
        regRead = r;
        regAddr = a;
        regWriteData = dat;
        if (r) noteQ.push_back(e);
        @(negedge clk);
    endtask
    task idle(input int n);
        repeat (n) op(0, 0, 8'h00, 8'h00, 8'h00);
    endtask
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test;
    end
    always @(posedge clk) readSeen <= regRead;
    always @(negedge clk) if (readSeen === 1'b1) begin
        note = noteQ.pop_front();
        `CHECK("readData", note, regReadData)
    end
    initial begin
        {rstn, regWrite, regRead, compareIn} = 4'h0;
        regAddr = 8'h00;
        regWriteData = 8'h00;
        repeat (16) @(negedge clk);
        rstn = 1;
        repeat (3) @(negedge clk);
        `CHECK("resp", 4'h4, responseSelect)
        op(0, 1, 8'h9d, 8'h00, 8'h02);
        op(1, 0, 8'h9d, 8'hff, 8'h00);
        op(0, 1, 8'h9d, 8'h00, 8'h33);
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d = {d[7:2], 2'(i)};
            op(1, 0, 8'h9d, d, 8'h00);
            op(0, 1, 8'h9d, 8'h00, d & 8'h33);
            `CHECK("resp", 4'h1 << 2'(i), responseSelect)
        end
        op(1, 0, 8'h9c, 8'h00, 8'h00);
        op(0, 1, 8'h9c, 8'h00, 8'h00);
        op(0, 1, 8'h9d, 8'h00, d & 8'h33);
        op(1, 0, 8'h9b, 8'h85, 8'h00);
        `CHECK("hyst", 4'h5, hysteresisSelect)
        `CHECK("enable", 1'b1, comparatorEnable)
        idle(comparator_mode_pkg::POWER_UP_CYCLES);
        op(1, 0, 8'h9b, 8'h80, 8'h00);
        op(1, 0, 8'h9d, 8'h20, 8'h00);
        compareIn = 1;
        idle(6);
        `CHECK("irq", 1'b1, comparatorIrq)
        `CHECK("pin", 1'b1, comparatorPinOut)
        op(0, 1, 8'h9b, 8'h00, 8'he0);
        compareIn = 0;
        idle(6);
        op(0, 1, 8'h9b, 8'h00, 8'hb0);
        op(1, 0, 8'h9d, 8'h00, 8'h00);
        idle(2);
        `CHECK("irq", 1'b0, comparatorIrq)
        op(1, 0, 8'h9d, 8'h10, 8'h00);
        idle(2);
        `CHECK("irq", 1'b1, comparatorIrq)
        op(1, 0, 8'h9b, 8'h80, 8'h00);
        idle(2);
        `CHECK("irq", 1'b0, comparatorIrq)
        op(0, 1, 8'h9b, 8'h00, 8'h80);
        compareIn = 1;
        op(1, 0, 8'h9b, 8'h00, 8'h00);
        idle(6);
        `CHECK("pin", 1'b0, comparatorPinOut)
        `CHECK("enable", 1'b0, comparatorEnable)
        stop_test;
    end
endmodule
